// ==== rtl/anab_pkg.sv ====
// Constants for the auto-negotiation ability register pair.
// Assumes a 5-bit management register address and 16-bit register data.
`default_nettype none
package anab_pkg;

    // Register offsets in the management map
    localparam logic [4:0] ANAB_OFF_ADVERT = 5'h04;
    localparam logic [4:0] ANAB_OFF_PARTNER = 5'h05;

    // Field positions shared by both registers
    localparam int ANAB_BIT_NEXT_PAGE = 15;
    localparam int ANAB_BIT_ACK = 14;
    localparam int ANAB_BIT_REM_FAULT = 13;
    localparam int ANAB_BIT_RSVD12 = 12;
    localparam int ANAB_BIT_ASYM_PAUSE = 11;
    localparam int ANAB_BIT_PAUSE = 10;
    localparam int ANAB_BIT_T4 = 9;
    localparam int ANAB_TECH_HI = 8;
    localparam int ANAB_TECH_LO = 5;
    localparam int ANAB_SEL_HI = 4;
    localparam int ANAB_SEL_LO = 0;

    // Values after reset
    localparam logic [15:0] ANAB_ADVERT_RST = 16'h01e1;
    localparam logic [15:0] ANAB_PARTNER_RST = 16'h0000;
    // Bits software can hold in the advertisement register
    localparam logic [15:0] ANAB_ADVERT_WMASK = 16'h8fff;
    // Bits of the partner word that are kept (bit 12 reserved)
    localparam logic [15:0] ANAB_PARTNER_MASK = 16'hefff;
    // Technology bits 8 down to 5
    localparam logic [15:0] ANAB_TECH_MASK = 16'h01e0;

    // Strap capture: synchroniser depth and settle count after reset
    localparam int ANAB_SYNC_STAGES = 3;
    localparam logic [1:0] ANAB_STRAP_SETTLE = 2'h3;

    // Strap capture states
    typedef enum logic [0:0] {
        ANAB_ST_WAIT = 1'b0,
        ANAB_ST_DONE = 1'b1
    } anab_strap_st_t;

endpackage : anab_pkg
`default_nettype wire

// ==== rtl/anab_strap_if.sv ====
// Carrier between the strap capture and the register bank.
// Assumes both ends on the management clock.
`timescale 1ns/10ps
`default_nettype none
interface anab_strap_if;
    logic load;
    logic value;
    modport source (output load, output value);
    modport sink (input load, input value);
endinterface : anab_strap_if
`default_nettype wire

// ==== rtl/anab_strap_capture.sv ====
// Samples the auto-negotiation-disable strap once after reset.
// Assumes the strap pin is asynchronous and steady around reset release.
`timescale 1ns/10ps
`default_nettype none
module anab_strap_capture
    import anab_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic autoneg_disable_strap_in,
    anab_strap_if.source strap
);

    logic [ANAB_SYNC_STAGES-1:0] sync_r;
    logic [1:0] settle_r;
    logic [1:0] settle_nxt;
    anab_strap_st_t state_r;
    anab_strap_st_t state_nxt;
    logic agree;
    logic value_r;
    logic load_r;

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage synchroniser on the strap pin
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            sync_r <= '0;
        else
            sync_r <= {sync_r[ANAB_SYNC_STAGES-2:0], autoneg_disable_strap_in};
    end

    // Only stages two and three are looked at
    assign agree = (sync_r[1] == sync_r[2]);
    assign settle_nxt = (settle_r == ANAB_STRAP_SETTLE) ? settle_r : settle_r + 2'h1;
    assign state_nxt = (state_r == ANAB_ST_WAIT && settle_r == ANAB_STRAP_SETTLE && agree)
                       ? ANAB_ST_DONE : state_r;

    ////////////////////////////////////////////////////////////////////////////
    // One-shot capture once the chain is filled
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            settle_r <= 2'h0;
            state_r <= ANAB_ST_WAIT;
            load_r <= 1'b0;
            value_r <= 1'b0;
        end
        else
        begin
            settle_r <= settle_nxt;
            state_r <= state_nxt;
            load_r <= (state_r == ANAB_ST_WAIT) && (state_nxt == ANAB_ST_DONE);
            if (state_r == ANAB_ST_WAIT)
                value_r <= sync_r[2];
        end
    end

    assign strap.load = load_r;
    assign strap.value = value_r;

endmodule : anab_strap_capture
`default_nettype wire

// ==== rtl/anab_registers.sv ====
// Auto-negotiation advertisement and link-partner ability registers.
// Assumes a management frame engine on mclk_in drives the register port,
// and the arbitration logic hands over each received base link code word.
// The strap is sampled once after reset; it must be steady when reset ends.
`timescale 1ns/10ps
`default_nettype none
module anab_registers
    import anab_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic autoneg_disable_strap_in,
    input wire logic autoneg_enable_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic reg_hit_out,
    input wire logic lcw_rx_valid_in,
    input wire logic [15:0] lcw_rx_word_in,
    output logic [15:0] lcw_tx_word_out
);

    // Address match, used for writes, reads and the hit flag
    function automatic logic anab_hit(input logic [4:0] addr, input logic [4:0] off);
        anab_hit = (addr == off);
    endfunction : anab_hit

    // Bits that software may write; reserved bits and remote fault stay zero
    function automatic logic anab_adv_rw(input int idx);
        anab_adv_rw = ANAB_ADVERT_WMASK[idx[3:0]];
    endfunction : anab_adv_rw

    // Duplex ability bits that the strap loads once after reset
    function automatic logic anab_adv_strap(input int idx);
        anab_adv_strap = (idx >= ANAB_TECH_LO) && (idx <= ANAB_TECH_HI);
    endfunction : anab_adv_strap

    // Partner bits that follow the received word; bit 12 is reserved
    function automatic logic anab_lp_kept(input int idx);
        anab_lp_kept = (idx != ANAB_BIT_RSVD12);
    endfunction : anab_lp_kept

    anab_strap_if strap_if ();

    logic [15:0] advert_r;
    logic [15:0] advert_nxt;
    logic [15:0] partner_r;
    logic [15:0] partner_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic rvalid_r;
    logic hit_advert;
    logic hit_partner;
    logic adv_wr_en;
    logic strap_load;
    logic strap_clear;
    logic rd_sel_advert;
    logic rd_sel_partner;
    logic rd_sel_none;
    // Field views of the partner word
    logic lp_next_page;
    logic lp_ack;
    logic lp_rem_fault;
    logic lp_asym_pause;
    logic lp_pause;
    logic [4:0] lp_abil;
    logic [4:0] lp_sel;
    logic [15:0] partner_rd;
    // Field views of the transmitted word
    logic tx_next_page;
    logic tx_asym_pause;
    logic tx_pause;
    logic tx_t4;
    logic [3:0] tx_tech;
    logic [4:0] tx_sel;

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture
    anab_strap_capture u_strap (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .autoneg_disable_strap_in(autoneg_disable_strap_in),
        .strap(strap_if.source)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    assign hit_advert = anab_hit(reg_addr_in, ANAB_OFF_ADVERT);
    assign hit_partner = anab_hit(reg_addr_in, ANAB_OFF_PARTNER);
    assign reg_hit_out = hit_advert | hit_partner;

    // Write enable of the advertisement register
    assign adv_wr_en = reg_wr_in && hit_advert;

    // Strap hand-over from the capture block
    assign strap_load = strap_if.load;
    assign strap_clear = strap_if.value;

    ////////////////////////////////////////////////////////////////////////////
    // Next value of each advertisement bit; a write wins over the strap load
    for (genvar i = 0; i < 16; i++)
    begin : g_adv
        logic wr_bit;
        logic load_bit;
        // Fixed bits write as zero; strap high withdraws the duplex abilities
        assign wr_bit = anab_adv_rw(i) ? reg_wdata_in[i] : 1'b0;
        assign load_bit = anab_adv_strap(i) ? !strap_clear : advert_r[i];
        assign advert_nxt[i] = adv_wr_en ? wr_bit
                             : strap_load ? load_bit
                             : advert_r[i];
    end : g_adv

    ////////////////////////////////////////////////////////////////////////////
    // Next value of each partner bit; bus writes never reach it
    for (genvar i = 0; i < 16; i++)
    begin : g_lp
        // Reserved bit 12 never loads
        assign partner_nxt[i] = !anab_lp_kept(i) ? 1'b0
                              : lcw_rx_valid_in ? lcw_rx_word_in[i]
                              : partner_r[i];
    end : g_lp

    ////////////////////////////////////////////////////////////////////////////
    // Partner word as read back, field by field
    assign lp_next_page = partner_r[ANAB_BIT_NEXT_PAGE];
    assign lp_ack = partner_r[ANAB_BIT_ACK];
    assign lp_rem_fault = partner_r[ANAB_BIT_REM_FAULT];
    assign lp_asym_pause = partner_r[ANAB_BIT_ASYM_PAUSE];
    assign lp_pause = partner_r[ANAB_BIT_PAUSE];
    assign lp_abil = partner_r[ANAB_BIT_T4:ANAB_TECH_LO];
    assign lp_sel = partner_r[ANAB_SEL_HI:ANAB_SEL_LO];
    // Reserved bit 12 reads zero
    assign partner_rd = {lp_next_page, lp_ack, lp_rem_fault, 1'b0,
                         lp_asym_pause, lp_pause,
                         lp_abil, lp_sel};

    ////////////////////////////////////////////////////////////////////////////
    // Read selection; unmapped offsets read zero, no read keeps the last value
    assign rd_sel_advert = reg_rd_in && hit_advert;
    assign rd_sel_partner = reg_rd_in && hit_partner;
    assign rd_sel_none = reg_rd_in && !reg_hit_out;
    assign rdata_nxt = rd_sel_advert ? advert_r
                     : rd_sel_partner ? partner_rd
                     : rd_sel_none ? 16'h0000
                     : rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Advertisement register
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            advert_r <= ANAB_ADVERT_RST;
        else
            advert_r <= advert_nxt;
    end

    // Partner register, zero until a word arrives
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            partner_r <= ANAB_PARTNER_RST;
        else
            partner_r <= partner_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, held until the next read
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_r <= 16'h0000;
        else
            rdata_r <= rdata_nxt;
    end

    // One-cycle read valid
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            rvalid_r <= 1'b0;
        else
            rvalid_r <= reg_rd_in;
    end

    // Register port outputs
    assign reg_rdata_out = rdata_r;
    assign reg_rvalid_out = rvalid_r;

    ////////////////////////////////////////////////////////////////////////////
    // Transmitted base word, field by field
    assign tx_next_page = advert_r[ANAB_BIT_NEXT_PAGE];
    assign tx_asym_pause = advert_r[ANAB_BIT_ASYM_PAUSE];
    assign tx_pause = advert_r[ANAB_BIT_PAUSE];
    assign tx_t4 = advert_r[ANAB_BIT_T4];
    // Forced speed and duplex: technology bits are not offered
    assign tx_tech = autoneg_enable_in ? advert_r[ANAB_TECH_HI:ANAB_TECH_LO] : 4'h0;
    assign tx_sel = advert_r[ANAB_SEL_HI:ANAB_SEL_LO];

    // Reserved bits and the unsupported remote fault go out as zero
    assign lcw_tx_word_out = {tx_next_page, 1'b0, 1'b0, 1'b0,
                              tx_asym_pause, tx_pause, tx_t4,
                              tx_tech, tx_sel};

endmodule : anab_registers
`default_nettype wire

// ==== test/anab_registers_props.sv ====
// Port checker for the ability register pair.
// Assumes it is bound onto anab_registers.
`timescale 1ns/10ps
`default_nettype none
module anab_registers_props
    import anab_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic autoneg_disable_strap_in,
    input wire logic autoneg_enable_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic reg_hit_out,
    input wire logic lcw_rx_valid_in,
    input wire logic [15:0] lcw_rx_word_in,
    input wire logic [15:0] lcw_tx_word_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    // Access decodes
    wire logic rd_a = reg_rd_in && reg_addr_in == ANAB_OFF_ADVERT;
    wire logic wr_a = reg_wr_in && reg_addr_in == ANAB_OFF_ADVERT;
    wire logic rd_p = reg_rd_in && reg_addr_in == ANAB_OFF_PARTNER;
    // Map, read path and transmitted word
    hit_decode_a: assert property (reg_hit_out == (reg_addr_in inside {5'h04, 5'h05}))
        else $error("hit flag wrong");
    read_valid_a: assert property (reg_rvalid_out == $past(reg_rd_in))
        else $error("read answer timing wrong");
    rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");
    partner_load_a: assert property (lcw_rx_valid_in ##1 (rd_p && !lcw_rx_valid_in) |=>
        reg_rdata_out == ($past(lcw_rx_word_in, 2) & ANAB_PARTNER_MASK)) else $error("partner");
    rsvd_zero_a: assert property (rd_p |=> !reg_rdata_out[ANAB_BIT_RSVD12])
        else $error("reserved partner bit set");
    advert_rw_a: assert property (wr_a ##1 (rd_a && !reg_wr_in) |=>
        reg_rdata_out == ($past(reg_wdata_in, 2) & ANAB_ADVERT_WMASK)) else $error("advert");
    tx_follow_a: assert property (wr_a ##1 autoneg_enable_in |->
        lcw_tx_word_out == ($past(reg_wdata_in) & ANAB_ADVERT_WMASK)) else $error("tx word");
    forced_mask_a: assert property (!autoneg_enable_in |-> !(|lcw_tx_word_out[8:5]))
        else $error("tech bits sent in forced mode");
    tx_rsvd_a: assert property (lcw_tx_word_out[14:12] == 3'h0)
        else $error("reserved or fault bit sent");
    // Main scenarios
    cover property (lcw_rx_valid_in ##1 rd_p);
    cover property (wr_a ##1 rd_a);
    cover property (!autoneg_enable_in && wr_a);
endmodule : anab_registers_props
bind anab_registers anab_registers_props u_anab_registers_props (.*);
`default_nettype wire

// ==== test/anab_link_partner.sv ====
// Link partner model handing over received base link code words.
// Assumes the bench asks for each word with a one-cycle send pulse.
`timescale 1ns/10ps
`default_nettype none
module anab_link_partner
(
    input wire logic mclk_in,
    input wire logic send_in,
    input wire logic [15:0] word_in,
    output logic lcw_valid_out = 1'b0,
    output logic [15:0] lcw_word_out = 16'h0000
);
    // One-cycle valid per word; word line toggles between words
    always_ff @(posedge mclk_in)
    begin
        lcw_valid_out <= send_in;
        lcw_word_out <= send_in ? word_in : ~lcw_word_out;
    end
endmodule : anab_link_partner
`default_nettype wire

// ==== test/autoneg_ability_registers_tb.sv ====
// Bench for the ability register pair: table of writes, then special cases.
// Assumes the partner model feeds the received code words.
`timescale 1ns/10ps
`default_nettype none
module autoneg_ability_registers_tb
    import anab_pkg::*;
;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic autoneg_disable_strap_in = 1'b0;
    logic autoneg_enable_in = 1'b1;
    logic [4:0] reg_addr_in = 5'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic [15:0] reg_rdata_out, lcw_rx_word_in, lcw_tx_word_out;
    logic reg_rvalid_out, reg_hit_out, lcw_rx_valid_in;
    logic send = 1'b0;
    logic [15:0] sword = 16'h0000;
    int n_errors = 0;
    int tests_run = 0;
    logic [31:0] rows [8] = '{32'hffff_8fff, 32'h0000_0000, 32'h0400_0400, 32'h0200_0200,
        32'h0180_0180, 32'h0060_0060, 32'h201f_001f, 32'h0801_0801};
    logic [31:0] lp_rows [3] = '{32'hffff_efff, 32'h8421_8421, 32'h5000_4000};
    // Clock, design and partner
    always #5 mclk_in = ~mclk_in;
    anab_registers u_anab_registers (.*);
    anab_link_partner u_anab_link_partner (.mclk_in(mclk_in), .send_in(send), .word_in(sword),
        .lcw_valid_out(lcw_rx_valid_in), .lcw_word_out(lcw_rx_word_in));
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Bus accesses, partner words and reset, all started at a falling edge
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge mclk_in);
        reg_wr_in = 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] hit_exp;
        hit_exp = {15'h0000, (a == ANAB_OFF_ADVERT) || (a == ANAB_OFF_PARTNER)};
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge mclk_in);
        reg_rd_in = 1'b0;
        chk("rvalid", {15'h0000, reg_rvalid_out}, 16'h0001);
        chk("rdata", reg_rdata_out, exp);
        chk("hit", {15'h0000, reg_hit_out}, hit_exp);
        // Idle edge so a following read raises its strobe at a later step
        @(negedge mclk_in);
    endtask : rd
    // One-cycle send pulse, then one edge for the partner register to load
    task automatic lp(input logic [15:0] w);
        sword = w;
        send = 1'b1;
        @(negedge mclk_in);
        send = 1'b0;
        @(negedge mclk_in);
    endtask : lp
    task automatic rst_pulse(input logic s, input int n);
        autoneg_disable_strap_in = s;
        rst_in = 1'b1;
        repeat (n) @(negedge mclk_in);
        rst_in = 1'b0;
        repeat (8) @(negedge mclk_in);
    endtask : rst_pulse
    task automatic stop_test;
        $display("mismatches %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    // Table, partner words, forced mode, unmapped read, resets
    initial
    begin
        rst_pulse(1'b0, 16);
        foreach (rows[i])
        begin
            wr(ANAB_OFF_ADVERT, rows[i][31:16]);
            chk("tx word", lcw_tx_word_out, rows[i][15:0]);
            rd(ANAB_OFF_ADVERT, rows[i][15:0]);
        end
        foreach (lp_rows[i])
        begin
            lp(lp_rows[i][31:16]);
            rd(ANAB_OFF_PARTNER, lp_rows[i][15:0]);
        end
        wr(ANAB_OFF_PARTNER, 16'h0000);
        rd(ANAB_OFF_PARTNER, 16'h4000);
        autoneg_enable_in = 1'b0;
        wr(ANAB_OFF_ADVERT, 16'h01ff);
        chk("forced tx", lcw_tx_word_out, 16'h001f);
        rd(ANAB_OFF_ADVERT, 16'h01ff);
        autoneg_enable_in = 1'b1;
        rd(5'h06, 16'h0000);
        rst_pulse(1'b0, 2);
        rd(ANAB_OFF_ADVERT, 16'h01e1);
        rd(ANAB_OFF_PARTNER, 16'h0000);
        rst_pulse(1'b1, 2);
        rd(ANAB_OFF_ADVERT, 16'h0001);
        stop_test();
    end
endmodule : autoneg_ability_registers_tb
`default_nettype wire
